// *** rtl/mfr_pkg.sv ***
// constants, types and register map of the multi-frame receive buffer
// assumes a 125 MHz core clock and a receiver/transmitter on the same clock
package mfr_pkg;
  // timing
  localparam int unsigned CLK_KHZ        = 125000;
  localparam int unsigned RF_KHZ         = 13560;
  localparam int unsigned GAP_MIN_RF_CYC = 2;
  localparam int unsigned GAP_MAX_NS     = 2000;
  localparam int unsigned GAP_MIN_CYC    = (GAP_MIN_RF_CYC * CLK_KHZ + RF_KHZ - 1) / RF_KHZ;
  localparam int unsigned GAP_MAX_CYC    = GAP_MAX_NS * (CLK_KHZ / 1000) / 1000;
  // buffer geometry
  localparam int unsigned BUF_BYTES   = 256;
  localparam int unsigned SLICE_BYTES = 32;
  localparam int unsigned MAX_FRAMES  = BUF_BYTES / SLICE_BYTES;
  localparam int unsigned MAX_PAYLOAD = 28;
  // slice status word: byte 28 count, byte 29 flags, bytes 30..31 zero
  localparam logic [4:0] STAT_CNT_POS = 5'h1c;
  localparam logic [4:0] STAT_FLG_POS = 5'h1d;
  localparam int unsigned FLG_COMB  = 0;
  localparam int unsigned FLG_INTEG = 1;
  localparam int unsigned FLG_FMT   = 2;
  localparam int unsigned FLG_COLL  = 3;
  localparam int unsigned FLG_LEN   = 4;
  // register map
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_CMD      = 12'h004;
  localparam logic [11:0] REG_EVT      = 12'h008;
  localparam logic [11:0] REG_RXSTAT   = 12'h00c;
  localparam logic [11:0] REG_BUF_BASE = 12'h100;
  localparam logic [11:0] BUF_MASK     = 12'hf00;
  localparam int unsigned CTRL_MULTI_BIT = 0;
  localparam logic        CTRL_MULTI_RST = 1'b0;
  localparam int unsigned EVT_RX_BIT     = 0;
  localparam int unsigned RXS_CNT_LSB    = 8;
  localparam int unsigned RXS_STATE_LSB  = 16;
  localparam logic [31:0] CMD_IDLE       = 32'h0000_0000;
  localparam logic [31:0] CMD_EXCHANGE   = 32'h0000_0003;

  typedef enum logic [1:0] {ST_IDLE, ST_AWAIT_SEND, ST_RECEIVE, ST_REARM} mfr_state_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } mfr_bus_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       frame_end;
    logic       crc_err;
    logic       coll;
  } mfr_rx_s;
endpackage

// *** rtl/mfr_rx_buffer.sv ***
// multi-frame receive buffer: slices the receive buffer per polled response
// assumes receiver bytes and frame-end pulses arrive on mclk, never together
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - multi-frame behaviour only with enable bit set and exchange machine running.
// - after each frame but the eighth in multi-frame mode the receiver re-arms by itself.
// - buffer split into 32-byte slices, so at most 8 responses per cycle.
// - frame n starts at byte 32 times frames already received; first at 0.
// - at most 28 payload bytes per frame go into a slice.
// - slice bytes 28..31 hold count, combined, individual and length error flags.
// - combined error is OR of integrity, frame format and collision flags.
// - length error when length byte above 28 or fewer bytes than announced.
// - reserved status bits are written as zero.
// - good CRC, no collision and matching count up to 28 store data with a clean status word.
// - CRC failure with right length stores data, sets combined and integrity.
// - length byte above 28 stores no payload but still writes status.
// - fewer bytes than a length byte of at most 28 stores data and sets frame format error.
// - receive-done event set once per frame received.
// - frames-captured field updated when reception ends.
// - after the eighth frame the machine goes to the await-send state.
// - idle command ends a multi-frame cycle early and stops reception.
// - frames-captured count cleared at start of each reception cycle.
// - receiver off at least 2 carrier cycles, at most about 2 us, between frames.
module mfr_rx_buffer
  import mfr_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // register port
  input  wire mfr_bus_s    bus,
  output logic      [31:0] reg_rdata,
  // receiver and transmitter
  input  wire mfr_rx_s     rx,
  input  wire logic        tx_done,
  output logic             rx_on,
  output logic             multi_active
);

  localparam int A_GMIN = GAP_MIN_CYC;
  localparam int A_GMAX = GAP_MAX_CYC;

  mfr_state_e  state_r;
  mfr_state_e  state_nxt;
  logic        ctrl_multi_r;
  logic        evt_rx_r;
  logic [3:0]  frames_r;
  logic [3:0]  frames_pub_r;
  logic [7:0]  cnt_r;
  logic [7:0]  len_r;
  logic [7:0]  last_cnt_r;
  logic [7:0]  gap_r;
  logic [31:0] rdata_r;
  logic [7:0]  buf_r [BUF_BYTES];

  // register decode
  wire logic sel_ctrl   = bus.addr == REG_CTRL;
  wire logic sel_cmd    = bus.addr == REG_CMD;
  wire logic sel_evt    = bus.addr == REG_EVT;
  wire logic sel_rxstat = bus.addr == REG_RXSTAT;
  wire logic sel_buf    = (bus.addr & BUF_MASK) == REG_BUF_BASE;
  wire logic cmd_wr     = bus.wr && sel_cmd;
  wire logic idle_cmd   = cmd_wr && bus.wdata == CMD_IDLE;
  wire logic exch_cmd   = cmd_wr && bus.wdata == CMD_EXCHANGE;
  wire logic evt_clr    = bus.wr && sel_evt && bus.wdata[EVT_RX_BIT];

  // receive path
  wire logic       running   = state_r != ST_IDLE;
  wire logic       multi_on  = ctrl_multi_r && running;
  wire logic       rx_take   = rx.valid && state_r == ST_RECEIVE;
  wire logic       fe        = rx.frame_end && state_r == ST_RECEIVE;
  wire logic       first     = cnt_r == 8'h00;
  wire logic [7:0] len_now   = first ? rx.data : len_r;
  wire logic       len_over  = len_now > 8'(MAX_PAYLOAD);
  // an oversize length byte keeps the whole frame out of the slice
  wire logic       multi_ok  = !len_over && cnt_r < 8'(MAX_PAYLOAD);
  wire logic       store_we  = rx_take && (multi_on ? multi_ok : cnt_r != 8'hff);
  wire logic [7:0] wr_addr   = multi_on ? {frames_r[2:0], cnt_r[4:0]} : cnt_r;
  wire logic       last_slot = frames_r == 4'(MAX_FRAMES - 1);

  // status flags of the frame that ends now; an empty frame counts as no length byte
  wire logic       f_len_big = !first && len_r > 8'(MAX_PAYLOAD);
  wire logic       f_short   = !first && cnt_r < len_r;
  wire logic       f_len     = f_len_big || f_short;
  wire logic       f_fmt     = !first && cnt_r != len_r;
  wire logic       f_integ   = rx.crc_err;
  wire logic       f_coll    = rx.coll;
  wire logic       f_comb    = f_integ || f_fmt || f_coll;
  // flag byte layout for the host, frozen: bit 0 combined, bit 1 integrity, bit 2 frame format,
  // bit 3 collision, bit 4 length, bits 7:5 zero. built as a concatenation so that no
  // one-bit shift can lose its flag to operand sizing
  wire logic [7:0] flag_byte = {3'h0, f_len, f_coll, f_fmt, f_integ, f_comb};
  wire logic       stat_we   = fe && multi_on;

  // buffer storage, one flip-flop byte per entry
  for (genvar i = 0; i < BUF_BYTES; i++) begin : g_buf
    localparam logic [7:0] IDX = 8'(i);
    wire logic       in_slice = stat_we && IDX[7:5] == frames_r[2:0];
    wire logic [7:0] stat_val = IDX[4:0] == STAT_CNT_POS ? cnt_r
                              : IDX[4:0] == STAT_FLG_POS ? flag_byte : 8'h00;
    always_ff @(posedge mclk) begin
      if (store_we && wr_addr == IDX) begin
        buf_r[i] <= rx.data;
      end else if (in_slice && IDX[4:0] >= STAT_CNT_POS) begin
        buf_r[i] <= stat_val;
      end
    end
  end

  // state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (exch_cmd) begin
          state_nxt = ST_AWAIT_SEND;
        end
      end
      ST_AWAIT_SEND: begin
        if (tx_done) begin
          state_nxt = ST_RECEIVE;
        end
      end
      ST_RECEIVE: begin
        if (fe) begin
          state_nxt = (multi_on && !last_slot) ? ST_REARM : ST_AWAIT_SEND;
        end
      end
      ST_REARM: begin
        if (gap_r == 8'h00) begin
          state_nxt = ST_RECEIVE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (idle_cmd) begin
      state_nxt = ST_IDLE;
    end
  end

  // a cycle opens on tx_done and closes on the last frame or on an idle command;
  // an idle command outside reception leaves the published count alone
  wire logic cycle_start = state_r == ST_AWAIT_SEND && tx_done && !idle_cmd;
  wire logic cycle_end   = (fe && state_nxt == ST_AWAIT_SEND)
                        || (idle_cmd && (state_r == ST_RECEIVE || state_r == ST_REARM));
  wire logic [3:0] frames_inc = frames_r + 4'h1;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      gap_r   <= 8'h00;
    end else begin
      state_r <= state_nxt;
      // the receiver stays off for the whole count, which sits well below 2 us
      if (fe) begin
        gap_r <= 8'(GAP_MIN_CYC - 1);
      end else if (state_r == ST_REARM && gap_r != 8'h00) begin
        gap_r <= gap_r - 8'h01;
      end
    end
  end

  // frame counters and per-frame byte count
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frames_r     <= 4'h0;
      frames_pub_r <= 4'h0;
      cnt_r        <= 8'h00;
      len_r        <= 8'h00;
      last_cnt_r   <= 8'h00;
    end else begin
      if (cycle_start) begin
        frames_r     <= 4'h0;
        frames_pub_r <= 4'h0;
      end else if (cycle_end) begin
        frames_pub_r <= fe ? frames_inc : frames_r;
      end
      if (fe) begin
        frames_r   <= frames_inc;
        last_cnt_r <= cnt_r;
        cnt_r      <= 8'h00;
        len_r      <= 8'h00;
      end else if (rx_take) begin
        cnt_r <= (cnt_r == 8'hff) ? cnt_r : cnt_r + 8'h01;
        if (first) begin
          len_r <= rx.data;
        end
      end
      if (idle_cmd) begin
        cnt_r <= 8'h00;
        len_r <= 8'h00;
      end
    end
  end

  // control and event registers; a new event beats a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_multi_r <= CTRL_MULTI_RST;
      evt_rx_r     <= 1'b0;
    end else begin
      if (bus.wr && sel_ctrl) begin
        ctrl_multi_r <= bus.wdata[CTRL_MULTI_BIT];
      end
      if (fe) begin
        evt_rx_r <= 1'b1;
      end else if (evt_clr) begin
        evt_rx_r <= 1'b0;
      end
    end
  end

  // read mux; buffer words are little endian
  // the buffer is not reset, so slices of frames never received read back as garbage
  wire logic [5:0]  word_idx = bus.addr[7:2];
  wire logic [31:0] buf_word = {buf_r[{word_idx, 2'd3}], buf_r[{word_idx, 2'd2}],
                                buf_r[{word_idx, 2'd1}], buf_r[{word_idx, 2'd0}]};
  wire logic [31:0] rxstat   = 32'(frames_pub_r) | (32'(last_cnt_r) << RXS_CNT_LSB)
                             | (32'(state_r) << RXS_STATE_LSB);
  wire logic [31:0] rd_val   = sel_ctrl   ? 32'(ctrl_multi_r) << CTRL_MULTI_BIT
                             : sel_evt    ? 32'(evt_rx_r) << EVT_RX_BIT
                             : sel_rxstat ? rxstat
                             : sel_buf    ? buf_word : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= bus.rd ? rd_val : 32'h0000_0000;
    end
  end

  assign reg_rdata    = rdata_r;
  assign rx_on        = state_r == ST_RECEIVE;
  assign multi_active = multi_on;

  // checking helpers
  logic [7:0] chk_base_r;
  logic [8:0] off_len_r;
  logic       chk_comb_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      chk_base_r <= 8'h00;
      off_len_r  <= 9'h000;
      chk_comb_r <= 1'b0;
    end else begin
      if (stat_we) begin
        chk_base_r <= {frames_r[2:0], 5'h00};
        chk_comb_r <= rx.crc_err || rx.coll || f_fmt;
      end
      off_len_r <= (state_r == ST_REARM) ? off_len_r + 9'h001 : 9'h000;
    end
  end

  // the flag byte of the slice just closed, seen one cycle after its status write
  wire logic [7:0] chk_flags = buf_r[chk_base_r + 8'(STAT_FLG_POS)];

  sequence s_clean_close;
    stat_we && !first && !rx.crc_err && !rx.coll && cnt_r == len_r && len_r <= 8'(MAX_PAYLOAD);
  endsequence

  sequence s_crc_close;
    stat_we && !first && rx.crc_err && cnt_r == len_r;
  endsequence

  sequence s_short_close;
    stat_we && !first && cnt_r < len_r;
  endsequence

  sequence s_mid_frame;
    fe && multi_on && !last_slot && !idle_cmd;
  endsequence

  sequence s_last_frame;
    fe && multi_on && last_slot && !idle_cmd;
  endsequence

  a_rearm_window: assert property (@(posedge mclk) disable iff (!rst_b)
    s_mid_frame |=> !rx_on ##[A_GMIN-1:A_GMAX] rx_on)
    else $error("receiver not re-armed within the gap window");

  a_gap_length: assert property (@(posedge mclk) disable iff (!rst_b)
    ($past(state_r) == ST_REARM && state_r == ST_RECEIVE) |-> off_len_r >= 9'(GAP_MIN_CYC))
    else $error("receiver gap shorter than two carrier cycles");

  a_eighth_frame: assert property (@(posedge mclk) disable iff (!rst_b)
    s_last_frame |=> state_r == ST_AWAIT_SEND && frames_pub_r == 4'(MAX_FRAMES))
    else $error("eighth frame did not end the cycle");

  a_idle_stops: assert property (@(posedge mclk) disable iff (!rst_b)
    idle_cmd |=> (state_r == ST_IDLE && !rx_on) [*2])
    else $error("idle command did not stop reception");

  a_event_set: assert property (@(posedge mclk) disable iff (!rst_b)
    fe |=> evt_rx_r && $changed(frames_r))
    else $error("frame end did not raise the receive event");

  a_count_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    cycle_start |=> frames_r == 4'h0 && frames_pub_r == 4'h0 && rx_on)
    else $error("frame counts not cleared at cycle start");

  a_slice_bound: assert property (@(posedge mclk) disable iff (!rst_b)
    (store_we && multi_on) |-> wr_addr[4:0] < 5'(MAX_PAYLOAD) && !len_over)
    else $error("payload written past the slice limit");

  a_status_word: assert property (@(posedge mclk) disable iff (!rst_b)
    stat_we |=> buf_r[chk_base_r + 8'(STAT_FLG_POS)][FLG_COMB] == chk_comb_r
                && buf_r[chk_base_r + 8'(STAT_CNT_POS)] == $past(cnt_r))
    else $error("slice status word holds wrong count or combined flag");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    stat_we |=> buf_r[chk_base_r + 8'h1e] == 8'h00 && buf_r[chk_base_r + 8'h1f] == 8'h00
                && buf_r[chk_base_r + 8'(STAT_FLG_POS)][7:5] == 3'h0)
    else $error("reserved status bits not zero");

  a_single_mode: assert property (@(posedge mclk) disable iff (!rst_b)
    (fe && !multi_on) |=> state_r == ST_AWAIT_SEND || state_r == ST_IDLE)
    else $error("re-arm without multi-frame mode");

  a_read_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    !$past(bus.rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");

  a_clean_status: assert property (@(posedge mclk) disable iff (!rst_b)
    s_clean_close |=> chk_flags == 8'h00)
    else $error("clean frame left error flags set");

  a_crc_flags: assert property (@(posedge mclk) disable iff (!rst_b)
    s_crc_close |=> chk_flags[FLG_COMB] && chk_flags[FLG_INTEG])
    else $error("integrity failure not flagged");

  a_short_flags: assert property (@(posedge mclk) disable iff (!rst_b)
    s_short_close |=> chk_flags[FLG_FMT] && chk_flags[FLG_LEN])
    else $error("short frame not flagged");

  a_len_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    (stat_we && !first && len_r > 8'(MAX_PAYLOAD)) |=> chk_flags[FLG_LEN])
    else $error("oversize length byte not flagged");

  a_oversize_drop: assert property (@(posedge mclk) disable iff (!rst_b)
    (rx_take && multi_on && !first && len_r > 8'(MAX_PAYLOAD)) |-> !store_we)
    else $error("payload stored despite oversize length byte");

  a_slice_base: assert property (@(posedge mclk) disable iff (!rst_b)
    (store_we && multi_on && first) |-> wr_addr == 8'(SLICE_BYTES * frames_r))
    else $error("frame does not start at its slice base");

  a_count_publish: assert property (@(posedge mclk) disable iff (!rst_b)
    (fe && state_nxt == ST_AWAIT_SEND) |=> frames_pub_r == $past(frames_r) + 4'h1)
    else $error("published frame count wrong at reception end");

  a_event_wins: assert property (@(posedge mclk) disable iff (!rst_b)
    (fe && evt_clr) |=> evt_rx_r)
    else $error("event clear beat a new frame event");

  a_event_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    (evt_clr && !fe) |=> !evt_rx_r)
    else $error("receive event not cleared");

  a_gap_ceiling: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_r == ST_REARM) |-> off_len_r < 9'(A_GMAX))
    else $error("receiver gap longer than the ceiling");

endmodule

`default_nettype wire

// *** verification/mfr_card_model.sv ***
// cards answering in polling timeslots: one frame per call of send
// assumes the receiver takes bytes on mclk only while rx_on is high
`timescale 1ns/1ns
`default_nettype none
module mfr_card_model
  import mfr_pkg::*;
(
  // clock
  input  wire logic    mclk,
  // receiver side
  input  wire logic    rx_on,
  output var  mfr_rx_s rx
);
  initial rx = '0;

  // length byte first, then a1, a2 ... as payload
  task automatic send(input logic [7:0] len, input int n, input logic crc, input logic coll);
    int i;
    i = 0;
    while (rx_on !== 1'b1 && i < 200) begin
      @(posedge mclk);
      i++;
    end
    for (i = 0; i < n; i++) begin
      @(posedge mclk);
      rx.valid <= 1'b1;
      rx.data  <= (i == 0) ? len : 8'(8'ha0 + i);
    end
    // a released data line must not keep its last value
    @(posedge mclk);
    rx.valid <= 1'b0;
    rx.data  <= ~rx.data;
    @(posedge mclk);
    rx.frame_end <= 1'b1;
    rx.crc_err   <= crc;
    rx.coll      <= coll;
    @(posedge mclk);
    rx.frame_end <= 1'b0;
    rx.crc_err   <= ~crc;
    rx.coll      <= ~coll;
  endtask
endmodule
`default_nettype wire

// *** verification/mfr_rx_buffer_bench.sv ***
// self-checking bench of the multi-frame receive buffer
// assumes the card model drives rx; bus and tx_done come from here
`timescale 1ns/1ns
`default_nettype none
module mfr_rx_buffer_bench;
  import mfr_pkg::*;
  logic        mclk;
  logic        rst_b;
  logic        tx_done;
  mfr_bus_s    bus;
  logic [31:0] reg_rdata;
  mfr_rx_s     rx;
  logic        rx_on;
  logic        multi_active;
  logic [31:0] d;
  int          n_mismatch;
  int          num_checks;
  int          cyc;
  int          low_n;
  int          last_low;

  mfr_rx_buffer dut (.mclk(mclk), .rst_b(rst_b), .bus(bus), .reg_rdata(reg_rdata), .rx(rx),
                     .tx_done(tx_done), .rx_on(rx_on), .multi_active(multi_active));
  mfr_card_model card (.mclk(mclk), .rx_on(rx_on), .rx(rx));

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // length of the last receiver-off gap, plus the hang guard
  always @(posedge mclk) begin
    cyc++;
    if (!rx_on) low_n++;
    else begin
      if (low_n > 0) last_low = low_n;
      low_n = 0;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= v;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    chk(nm, e, reg_rdata & m);
  endtask

  task wait_on();
    int i;
    i = 0;
    while (rx_on !== 1'b1 && i < 100) begin
      @(posedge mclk);
      i++;
    end
    @(negedge mclk);
  endtask

  task go();
    wr(REG_CMD, CMD_EXCHANGE);
    @(posedge mclk);
    tx_done <= 1'b1;
    @(posedge mclk);
    tx_done <= 1'b0;
    @(negedge mclk);
  endtask

  // one card answer in multi-frame mode, slice k
  task frame(input int k, input logic [7:0] len, input int n, input logic crc, input logic coll,
             input logic [7:0] fl, input bit gap);
    logic [11:0] s;
    s = REG_BUF_BASE + 12'(SLICE_BYTES * k);
    card.send(len, n, crc, coll);
    rchk("evt", REG_EVT, '1, 32'h1);
    wr(REG_EVT, 32'h1);
    rchk("evt_clr", REG_EVT, '1, 32'h0);
    rchk("status", s + 12'h1c, '1, {16'h0, fl, 8'(n)});
    if (len == 8'(n) && n >= 4) rchk("payload", s, '1, {8'ha3, 8'ha2, 8'ha1, len});
    if (gap) begin
      wait_on();
      chk("gap", 32'(GAP_MIN_CYC), 32'(last_low));
    end
  endtask

  task t_reset();
    chk("rx_on", 32'h0, {31'h0, rx_on});
    rchk("ctrl", REG_CTRL, '1, 32'h0);
    wr(12'h0fc, 32'hffff_ffff);
    rchk("unmapped", 12'h0fc, '1, 32'h0);
    wr(REG_CTRL, 32'h1);
    rchk("ctrl_set", REG_CTRL, '1, 32'h1);
    chk("multi_idle", 32'h0, {31'h0, multi_active});
    $display("test reset done");
  endtask

  task t_multi();
    go();
    chk("multi_on", 32'h1, {31'h0, multi_active});
    frame(0, 8'h05, 5, 1'b0, 1'b0, 8'h00, 1);
    frame(1, 8'h06, 6, 1'b1, 1'b0, 8'h03, 1);
    frame(2, 8'h1e, 4, 1'b0, 1'b0, 8'h15, 1);
    frame(3, 8'h0a, 4, 1'b0, 1'b0, 8'h15, 1);
    frame(4, 8'h03, 3, 1'b0, 1'b1, 8'h09, 1);
    frame(5, 8'h1c, 28, 1'b0, 1'b0, 8'h00, 1);
    wr(REG_CMD, CMD_IDLE);
    rchk("rxstat_idle", REG_RXSTAT, '1, 32'h0000_1c06);
    chk("rx_off", 32'h0, {31'h0, rx_on});
    $display("test multi done");
  endtask

  task t_eight();
    int k;
    go();
    rchk("rxstat_clr", REG_RXSTAT, 32'h3000f, 32'h20000);
    for (k = 0; k < 8; k++) frame(k, 8'h02, 2, 1'b0, 1'b0, 8'h00, k < 7);
    rchk("rxstat_8", REG_RXSTAT, 32'h3000f, 32'h10008);
    chk("rx_off8", 32'h0, {31'h0, rx_on});
    $display("test eight done");
  endtask

  task t_single();
    wr(REG_CTRL, 32'h0);
    go();
    chk("multi_off", 32'h0, {31'h0, multi_active});
    card.send(8'h04, 4, 1'b0, 1'b0);
    rchk("evt_single", REG_EVT, '1, 32'h1);
    rchk("rxstat_1", REG_RXSTAT, 32'h3000f, 32'h10001);
    chk("no_rearm", 32'h0, {31'h0, rx_on});
    $display("test single done");
  endtask

  initial begin
    n_mismatch = 0;
    num_checks = 0;
    cyc        = 0;
    low_n      = 0;
    last_low   = 0;
    rst_b      = 1'b0;
    tx_done    = 1'b0;
    bus        = '0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_multi();
    t_eight();
    t_single();
    stop_test();
  end
endmodule
`default_nettype wire
